/* File: design/delay_limit_calc.sv */
// one delay limit: digital part plus rounded-up analog part
`timescale 1ns/10ps
`default_nettype none
`include "delay_limit_defs.svh"

module delay_limit_calc #(
  parameter int PERIOD_SIXT = 80
) (
  // timing parameter parts
  input wire logic [7:0] digital,
  input wire logic [7:0] analog,
  // result in whole clock ticks
  output logic [7:0] ticks
);

  localparam logic [12:0] PERIOD = 13'(PERIOD_SIXT);
  localparam logic [12:0] PERIOD_M1 = 13'(PERIOD_SIXT - 1);

  logic [11:0] step;
  logic [11:0] amount;
  logic [12:0] quot;
  logic [12:0] total;

  // ----------------------------------------------------------------
  // conversion in sixteenths of a nanosecond
  // ----------------------------------------------------------------
  always_comb begin
    step = `DLR_STEP_8NS_SIXT >> analog[`DLR_STEP_MSB:`DLR_STEP_LSB];
    amount = 12'(step * 12'(analog[`DLR_COUNT_MSB:`DLR_COUNT_LSB]));
    // ceiling division: any fraction of a tick costs a whole tick
    quot = 13'((13'(amount) + PERIOD_M1) / PERIOD);
    total = 13'(13'(digital) + quot);
    // field is only eight bits wide, so clamp rather than wrap
    if (total > 13'h00ff) begin
      ticks = 8'hff;
    end else begin
      ticks = total[7:0];
    end
  end

endmodule
`default_nettype wire

/* File: design/dram_delay_limit_readout.sv */
// minimum/maximum delay limit registers and their read packet answer
// How it works
// - request word two 10'h300 selects the maximum limit read.
// - request word two 10'h200 selects the minimum limit read.
// - minimum answer: four words, upper ten lines zero, PR PW BR BW low byte.
// - maximum answer: four words, upper ten lines zero, PR PW BR BW low byte.
// - each minimum is digital plus analog rounded up at fastest clock.
// - each maximum is digital plus analog rounded up at fastest clock.
// - page read limit is an unsigned eight-bit tick count, 0 to 255.
// - page write limit is an unsigned eight-bit tick count, 0 to 255.
// - bank read limit is an unsigned eight-bit tick count, 0 to 255.
// - minimum bank write limit is an unsigned eight-bit tick count.
// - maximum page/bank fields hold the largest supported delay, eight bits.
`timescale 1ns/10ps
`default_nettype none
`include "delay_limit_defs.svh"

module dram_delay_limit_readout #(
  parameter int MIN_PERIOD_PS = `DLR_MIN_CMD_CLK_PS
) (
  // system
  input wire logic clk_sys,
  input wire logic srst,
  // command link pins
  input wire logic command_clock,
  input wire logic request_flag,
  input wire logic [`DLR_CA_W-1:0] command_address_bus,
  // strap of this device's address
  input wire logic [`DLR_ID_W-1:0] target_device_id,
  // timing parameter parts, index 0..3 = page rd, page wr, bank rd, bank wr
  input wire logic [3:0][7:0] min_digital,
  input wire logic [3:0][7:0] min_analog,
  input wire logic [3:0][7:0] max_digital,
  input wire logic [3:0][7:0] max_analog,
  // data pins, driven only
  output logic [`DLR_DQ_W-1:0] data_lines,
  output logic data_lines_oe_n,
  // state seen by the rest of the device
  output logic [31:0] min_delay_limits,
  output logic [31:0] max_delay_limits,
  output logic answer_is_max
);

  localparam int SYNC_W = `DLR_CA_W + 2;
  localparam int PERIOD_SIXT =
    (MIN_PERIOD_PS * `DLR_SIXT_PER_NS) / `DLR_PS_PER_NS;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pack_limits(
    input logic [3:0][7:0] ticks
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`DLR_PAGE_READ_LSB +: 8] = ticks[0];
    w[`DLR_PAGE_WRITE_LSB +: 8] = ticks[1];
    w[`DLR_BANK_READ_LSB +: 8] = ticks[2];
    w[`DLR_BANK_WRITE_LSB +: 8] = ticks[3];
    return w;
  endfunction

  function automatic logic [`DLR_DQ_W-1:0] answer_word(
    input logic [31:0] limits,
    input logic [1:0] idx
  );
    logic [`DLR_DQ_W-1:0] w;
    w = {`DLR_DQ_W{1'b0}};
    w[7:0] = limits[{idx, 3'h0} +: 8];
    return w;
  endfunction

  // ----------------------------------------------------------------
  // limit arithmetic
  // ----------------------------------------------------------------
  logic [3:0][7:0] min_ticks;
  logic [3:0][7:0] max_ticks;

  for (genvar i = 0; i < 4; i++) begin : g_calc
    delay_limit_calc #(
      .PERIOD_SIXT(PERIOD_SIXT)
    ) u_min (
      .digital(min_digital[i]),
      .analog(min_analog[i]),
      .ticks(min_ticks[i])
    );
    delay_limit_calc #(
      .PERIOD_SIXT(PERIOD_SIXT)
    ) u_max (
      .digital(max_digital[i]),
      .analog(max_analog[i]),
      .ticks(max_ticks[i])
    );
  end

  logic [31:0] min_limits_r;
  logic [31:0] max_limits_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      min_limits_r <= `DLR_LIMITS_RESET;
      max_limits_r <= `DLR_LIMITS_RESET;
    end else begin
      min_limits_r <= pack_limits(min_ticks);
      max_limits_r <= pack_limits(max_ticks);
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // a change is accepted only once the 2nd and 3rd stages agree
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync3_r;
  logic [SYNC_W-1:0] stable_r;
  logic [SYNC_W-1:0] stable_nxt;
  logic clk_prev_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= {command_clock, request_flag, command_address_bus};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_comb begin
    stable_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) |
                 (stable_r & (sync2_r ^ sync3_r));
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stable_r <= '0;
      clk_prev_r <= 1'b0;
    end else begin
      stable_r <= stable_nxt;
      clk_prev_r <= stable_r[SYNC_W-1];
    end
  end

  logic cmd_rise;
  logic flag_lvl;
  logic [`DLR_CA_W-1:0] ca_lvl;

  assign cmd_rise = stable_r[SYNC_W-1] & ~clk_prev_r;
  assign flag_lvl = stable_r[SYNC_W-2];
  assign ca_lvl = stable_r[`DLR_CA_W-1:0];

  // ----------------------------------------------------------------
  // request capture and decode
  // ----------------------------------------------------------------
  delay_limit_pkg::link_state_e state_r;
  logic [1:0] word_cnt_r;
  logic [`DLR_CA_W-1:0] req_w0_r;
  logic [`DLR_CA_W-1:0] req_w1_r;
  logic [`DLR_CA_W-1:0] req_w2_r;
  logic hit_min;
  logic hit_max;
  logic head_ok;

  // word three arrives live on the edge that completes the packet
  always_comb begin
    head_ok = (req_w0_r[`DLR_CA_W-1:1] == target_device_id) &&
              req_w0_r[`DLR_W0_MARK_BIT] &&
              (req_w1_r[`DLR_W1_GROUP_MSB:`DLR_W1_GROUP_LSB] ==
               `DLR_W1_GROUP) &&
              (req_w1_r[`DLR_W1_LOW_MSB:`DLR_W1_LOW_LSB] == `DLR_W1_LOW) &&
              (ca_lvl == `DLR_W3_ZERO);
    hit_min = head_ok && (req_w2_r == `DLR_W2_SEL_MIN);
    hit_max = head_ok && (req_w2_r == `DLR_W2_SEL_MAX);
  end

  logic [31:0] answer_limits_r;
  logic answer_is_max_r;
  logic [1:0] ans_cnt_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= delay_limit_pkg::ST_IDLE;
      word_cnt_r <= 2'h0;
      req_w0_r <= '0;
      req_w1_r <= '0;
      req_w2_r <= '0;
      answer_limits_r <= `DLR_LIMITS_RESET;
      answer_is_max_r <= 1'b0;
      ans_cnt_r <= 2'h0;
    end else if (cmd_rise) begin
      unique case (state_r)
        delay_limit_pkg::ST_IDLE: begin
          // the flag marks the first word of a packet
          if (flag_lvl) begin
            req_w0_r <= ca_lvl;
            word_cnt_r <= 2'h1;
            state_r <= delay_limit_pkg::ST_COLLECT;
          end
        end
        delay_limit_pkg::ST_COLLECT: begin
          word_cnt_r <= 2'(word_cnt_r + 2'h1);
          if (word_cnt_r == 2'h1) begin
            req_w1_r <= ca_lvl;
          end else if (word_cnt_r == 2'h2) begin
            req_w2_r <= ca_lvl;
          end else if (hit_min || hit_max) begin
            // snapshot so a moving limit cannot tear the answer
            answer_limits_r <= hit_max ? max_limits_r : min_limits_r;
            answer_is_max_r <= hit_max;
            ans_cnt_r <= 2'h0;
            state_r <= delay_limit_pkg::ST_ANSWER;
          end else begin
            // other registers or other devices: not ours
            state_r <= delay_limit_pkg::ST_IDLE;
          end
        end
        delay_limit_pkg::ST_ANSWER: begin
          ans_cnt_r <= 2'(ans_cnt_r + 2'h1);
          if (ans_cnt_r == 2'(`DLR_ANS_WORDS - 1)) begin
            state_r <= delay_limit_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data pin drive
  // ----------------------------------------------------------------
  // requests arriving during an answer are not watched for
  logic [`DLR_DQ_W-1:0] data_r;
  logic data_oe_n_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_r <= {`DLR_DQ_W{1'b0}};
      data_oe_n_r <= 1'b1;
    end else if (state_r == delay_limit_pkg::ST_ANSWER) begin
      data_r <= answer_word(answer_limits_r, ans_cnt_r);
      data_oe_n_r <= 1'b0;
    end else begin
      data_r <= {`DLR_DQ_W{1'b0}};
      data_oe_n_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign data_lines = data_r;
  assign data_lines_oe_n = data_oe_n_r;
  assign min_delay_limits = min_limits_r;
  assign max_delay_limits = max_limits_r;
  assign answer_is_max = answer_is_max_r;

endmodule
`default_nettype wire

/* File: inc/delay_limit_defs.svh */
// constants for the delay limit readout block
`ifndef DELAY_LIMIT_DEFS_SVH
`define DELAY_LIMIT_DEFS_SVH

// ----------------------------------------------------------------
// link widths and packet shape
// ----------------------------------------------------------------
`define DLR_CA_W 10
`define DLR_DQ_W 18
`define DLR_ID_W 9
`define DLR_FIELD_W 8
`define DLR_REQ_WORDS 4
`define DLR_ANS_WORDS 4

// ----------------------------------------------------------------
// request word decode
// ----------------------------------------------------------------
`define DLR_W0_MARK_BIT 0
`define DLR_W1_GROUP_MSB 9
`define DLR_W1_GROUP_LSB 6
`define DLR_W1_GROUP 4'h2
`define DLR_W1_LOW_MSB 4
`define DLR_W1_LOW_LSB 0
`define DLR_W1_LOW 5'h00
`define DLR_W2_SEL_MIN 10'h200
`define DLR_W2_SEL_MAX 10'h300
`define DLR_W3_ZERO 10'h000

// ----------------------------------------------------------------
// limit register field positions (lsb of each byte)
// ----------------------------------------------------------------
`define DLR_PAGE_READ_LSB 0
`define DLR_PAGE_WRITE_LSB 8
`define DLR_BANK_READ_LSB 16
`define DLR_BANK_WRITE_LSB 24
`define DLR_LIMITS_RESET 32'h0000_0000

// ----------------------------------------------------------------
// analog step encoding and clock period
// ----------------------------------------------------------------
`define DLR_STEP_MSB 7
`define DLR_STEP_LSB 5
`define DLR_COUNT_MSB 4
`define DLR_COUNT_LSB 0
`define DLR_STEP_8NS_SIXT 12'h080
`define DLR_MIN_CMD_CLK_PS 5000
`define DLR_PS_PER_NS 1000
`define DLR_SIXT_PER_NS 16

`endif

/* File: inc/delay_limit_pkg.sv */
// types for the delay limit readout block
`include "delay_limit_defs.svh"
package delay_limit_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COLLECT,
    ST_ANSWER
  } link_state_e;

  typedef logic [`DLR_FIELD_W-1:0] field_t;

endpackage

/* File: test/ctrl_model.sv */
// memory controller model: request packets out, answer words in
`timescale 1ns/10ps
`default_nettype none
module ctrl_model (
  // system
  input wire logic clk_sys,
  // link pins
  output logic command_clock,
  output logic request_flag,
  output logic [9:0] command_address_bus,
  // answer pins
  input wire logic [17:0] data_lines,
  input wire logic data_lines_oe_n
);
  int drive_cnt = 0;
  initial begin
    command_clock = 1'b0;
    request_flag = 1'b0;
    command_address_bus = 10'h000;
  end
  // single writer: read_pkt only compares snapshots of the count
  always @(posedge clk_sys) if (!data_lines_oe_n) drive_cnt <= drive_cnt + 1;
  // one link period; clock stands low between frames
  task automatic tick(input logic f, input logic [9:0] ca,
      output logic [17:0] s);
    request_flag = f;
    command_address_bus = ca;
    repeat (4) @(negedge clk_sys);
    s = data_lines;
    command_clock = 1'b1;
    repeat (4) @(negedge clk_sys);
    command_clock = 1'b0;
  endtask
  // released bus shows the inverse of its last word, not a stale copy
  task automatic read_pkt(input logic [3:0][9:0] w,
      output logic [3:0][17:0] got, output logic any);
    logic [17:0] s;
    int c0;
    @(negedge clk_sys);
    c0 = drive_cnt;
    for (int k = 0; k < 8; k++) begin
      tick(k == 0, k < 4 ? w[k] : ~command_address_bus, s);
      if (k >= 4) got[k-4] = s;
    end
    repeat (8) @(negedge clk_sys);
    any = (drive_cnt != c0);
  endtask
endmodule
`default_nettype wire

/* File: test/dram_delay_limit_readout_checker.sv */
// port assertions for the delay limit readout
`timescale 1ns/10ps
`default_nettype none
`include "delay_limit_defs.svh"
module dram_delay_limit_readout_checker #(
  parameter int MIN_PERIOD_PS = `DLR_MIN_CMD_CLK_PS
) (
  // system
  input wire logic clk_sys,
  input wire logic srst,
  // timing parameter parts
  input wire logic [3:0][7:0] min_digital,
  input wire logic [3:0][7:0] min_analog,
  input wire logic [3:0][7:0] max_digital,
  input wire logic [3:0][7:0] max_analog,
  // answer pins and limit registers
  input wire logic [`DLR_DQ_W-1:0] data_lines,
  input wire logic data_lines_oe_n,
  input wire logic [31:0] min_delay_limits,
  input wire logic [31:0] max_delay_limits,
  input wire logic answer_is_max
);
  // period in sixteenths of a ns, same unit as the analog steps
  localparam int P = MIN_PERIOD_PS * 16 / 1000;
  function automatic logic [31:0] pk(input logic [3:0][7:0] d,
      input logic [3:0][7:0] a);
    logic [31:0] r;
    int s;
    for (int k = 0; k < 4; k++) begin
      s = d[k] + (a[k][4:0] * (128 >> a[k][7:5]) + P - 1) / P;
      r[8*k +: 8] = s > 255 ? 8'hff : s[7:0];
    end
    return r;
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_quiet; data_lines_oe_n |-> data_lines == 18'h00000; endproperty
  a_quiet: assert property (p_quiet) else $error("pins not quiet");
  property p_upper; !data_lines_oe_n |-> data_lines[17:8] == 10'h000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper lines set");
  property p_first_min;
    $fell(data_lines_oe_n) && !answer_is_max
      |-> data_lines[7:0] == min_delay_limits[7:0];
  endproperty
  a_first_min: assert property (p_first_min) else $error("min word0");
  property p_first_max;
    $fell(data_lines_oe_n) && answer_is_max
      |-> data_lines[7:0] == max_delay_limits[7:0];
  endproperty
  a_first_max: assert property (p_first_max) else $error("max word0");
  property p_len;
    $fell(data_lines_oe_n) |-> !data_lines_oe_n [*8] ##[20:32] data_lines_oe_n;
  endproperty
  a_len: assert property (p_len) else $error("answer length");
  property p_sel_hold;
    !data_lines_oe_n ##1 !data_lines_oe_n |-> $stable(answer_is_max);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved");
  property p_min_calc;
    !$past(srst) |->
      min_delay_limits == pk($past(min_digital), $past(min_analog));
  endproperty
  a_min_calc: assert property (p_min_calc) else $error("min calc");
  property p_max_calc;
    !$past(srst) |->
      max_delay_limits == pk($past(max_digital), $past(max_analog));
  endproperty
  a_max_calc: assert property (p_max_calc) else $error("max calc");
endmodule
bind dram_delay_limit_readout dram_delay_limit_readout_checker #(
  .MIN_PERIOD_PS(MIN_PERIOD_PS)) u_chk (.clk_sys(clk_sys), .srst(srst),
  .min_digital(min_digital), .min_analog(min_analog),
  .max_digital(max_digital), .max_analog(max_analog),
  .data_lines(data_lines), .data_lines_oe_n(data_lines_oe_n),
  .min_delay_limits(min_delay_limits), .max_delay_limits(max_delay_limits),
  .answer_is_max(answer_is_max));
`default_nettype wire

/* File: test/tb_dram_delay_limit_readout.sv */
// self-checking bench for the delay limit readout
`timescale 1ns/10ps
`default_nettype none
module tb_dram_delay_limit_readout;
  localparam int P = 5000 * 16 / 1000; // fastest clock, not link's
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic command_clock;
  logic request_flag;
  logic [9:0] command_address_bus;
  logic [8:0] id = 9'h000;
  logic [3:0][7:0] min_digital = '0;
  logic [3:0][7:0] min_analog = '0;
  logic [3:0][7:0] max_digital = '0;
  logic [3:0][7:0] max_analog = '0;
  logic [17:0] data_lines;
  logic data_lines_oe_n;
  logic [31:0] min_delay_limits;
  logic [31:0] max_delay_limits;
  logic answer_is_max;
  int fail_count = 0;
  int check_count = 0;
  always #25 clk_sys = ~clk_sys;
  dram_delay_limit_readout dut (.clk_sys(clk_sys), .srst(srst),
    .command_clock(command_clock), .request_flag(request_flag),
    .command_address_bus(command_address_bus), .target_device_id(id),
    .min_digital(min_digital), .min_analog(min_analog),
    .max_digital(max_digital), .max_analog(max_analog),
    .data_lines(data_lines), .data_lines_oe_n(data_lines_oe_n),
    .min_delay_limits(min_delay_limits), .max_delay_limits(max_delay_limits),
    .answer_is_max(answer_is_max));
  ctrl_model u_ctl (.clk_sys(clk_sys), .command_clock(command_clock),
    .request_flag(request_flag), .command_address_bus(command_address_bus),
    .data_lines(data_lines), .data_lines_oe_n(data_lines_oe_n));
  function automatic logic [31:0] pk(input logic [3:0][7:0] d,
      input logic [3:0][7:0] a);
    logic [31:0] r;
    int s;
    for (int k = 0; k < 4; k++) begin
      s = d[k] + (a[k][4:0] * (128 >> a[k][7:5]) + P - 1) / P;
      r[8*k +: 8] = s > 255 ? 8'hff : s[7:0];
    end
    return r;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic settle;
    repeat (2) @(negedge clk_sys);
    check(min_delay_limits, pk(min_digital, min_analog));
    check(max_delay_limits, pk(max_digital, max_analog));
    $display("limits done");
  endtask
  task automatic do_read(input logic [9:0] w2, input logic [9:0] w3,
      input logic [8:0] rid, input logic ok);
    logic [3:0][17:0] got;
    logic any;
    logic [31:0] lim;
    lim = w2[8] ? pk(max_digital, max_analog) : pk(min_digital, min_analog);
    u_ctl.read_pkt({w3, w2, 4'h2, 1'($urandom), 5'h00, rid, 1'b1}, got, any);
    check(any, ok);
    if (ok) begin
      check(answer_is_max, w2[8]);
      for (int k = 0; k < 4; k++)
        check(got[k], lim[8*k +: 8]);
    end
    $display("read done w2=%h w3=%h", w2, w3);
  endtask
  initial begin
    void'($urandom(32'hccd0));
    id = 9'($urandom);
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    repeat (6) @(negedge clk_sys);
    // zero analog, finest step, coarsest step, saturating sum
    min_digital = 32'hff10_0000;
    min_analog = 32'h0100_e11f;
    max_digital = 32'hffff_ffff; // at or above every minimum
    max_analog = 32'h0000_0000;
    settle();
    do_read(10'h200, 10'h000, id, 1'b1);
    do_read(10'h300, 10'h000, id, 1'b1);
    do_read(10'h300, 10'h000, id ^ 9'h001, 1'b0);
    do_read(10'h100, 10'h000, id, 1'b0);
    do_read(10'h200, 10'h001, id, 1'b0);
    for (int i = 0; i < 8; i++) begin
      min_digital = $urandom;
      min_analog = $urandom;
      max_digital = $urandom;
      max_analog = $urandom;
      settle();
      do_read(i[0] ? 10'h300 : 10'h200, 10'h000, id, 1'b1);
    end
    wrap_up();
  end
  initial begin
    #(3000 * 50);
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
